// [pgt_host_model.sv]
// Host side of the register port: one byte per strobe, held for one edge.
module pgt_host_model (
  input  wire logic       clk,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regWrEn,
  output logic            regRdEn
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle values at time zero, so the port never floats.
  initial
  begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end

  // A strobe is dropped one edge after raising it; a new call waits an edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
  endtask
endmodule // pgt_host_model

// [pgt_pkg.sv]
package pgt_pkg;

  // Byte addresses of the mask registers on the register port.
  localparam logic [7:0] PGT_ADDR_D_MASK_ONE = 8'hA6;
  localparam logic [7:0] PGT_ADDR_D_MASK_TWO = 8'hA7;
  localparam logic [7:0] PGT_ADDR_B_MASK_ONE = 8'hA8;

  // Reset values of the mask registers.
  localparam logic [7:0] PGT_RST_D_MASK_ONE = 8'h00;
  localparam logic [7:0] PGT_RST_D_MASK_TWO = 8'h00;
  localparam logic [7:0] PGT_RST_B_MASK_ONE = 8'hC0;

  // Field positions in the second mask register of output D.
  localparam int PGT_BIT_CONTROL_FIVE_EXCLUDE  = 7;
  localparam int PGT_BIT_CONTROL_FOUR_EXCLUDE  = 6;
  localparam int PGT_BIT_CONTROL_TWO_EXCLUDE   = 5;
  localparam int PGT_BIT_CONTROL_ONE_EXCLUDE   = 4;
  localparam int PGT_BIT_TERMINATION_EXCLUDE   = 3;
  localparam int PGT_BIT_SWITCH_B_TWO_EXCLUDE  = 2;
  localparam int PGT_BIT_SWITCH_B_ONE_EXCLUDE  = 1;
  localparam int PGT_BIT_LINEAR_A_THREE_EXCL   = 0;

  // Field positions in the first mask register of output B.
  localparam int PGT_BIT_LINEAR_A_TWO_EXCLUDE  = 7;
  localparam int PGT_BIT_SWITCH_A_ONE_EXCLUDE  = 6;
  localparam int PGT_BIT_STEP_DOWN_SIX_EXCLUDE = 5;
  localparam int PGT_BIT_STEP_DOWN_ONE_EXCLUDE = 0;

  // Field position in the first mask register of output D.
  localparam int PGT_BIT_D_STEP_DOWN_ONE_EXCL  = 0;

  // Number of step-down rails.
  localparam int PGT_STEP_DOWN_RAILS = 6;

  // Whole state of the block.
  typedef struct packed {
    logic [7:0] maskDTwo;
    logic [7:0] maskBOne;
    logic       maskDOneBit0;
    logic [7:0] rdData;
    logic       pgD;
    logic       pgB;
  } pgt_state_t;

endpackage : pgt_pkg

// [pgt_power_good_tree_masks.sv]
// Notes on behaviour
// - Output D second mask at A7h, 8-bit read/write, resets to 00h.
// - D mask bit 7 set excludes control input five from output D.
// - D mask bit 6 set excludes control input four from output D.
// - D mask bits 5 and 4 exclude control inputs two and one.
// - D mask bit 3 set removes termination LDO good from output D.
// - D mask bit 2 set excludes load switch B2 status from output D.
// - D mask bit 1 set excludes load switch B1 good from output D.
// - D mask bit 0 set excludes linear regulator A3 good from output D.
// - Output B first mask at A8h, 8-bit read/write, resets to C0h.
// - B mask bit 7 excludes linear regulator A2; resets set, so ignored.
// - B mask bit 6 excludes load switch A1; resets set, so ignored.
// - B mask bits 5..0 exclude step-down rails 6..1; reset cleared.
// - D first mask bit 0 excludes step-down rail 1; resets cleared.
module pgt_power_good_tree_masks
  import pgt_pkg::*;
#(
  parameter int RAILS = PGT_STEP_DOWN_RAILS
)
(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [7:0]       regAddr,
  input  wire logic [7:0]       regWrData,
  input  wire logic             regWrEn,
  input  wire logic             regRdEn,
  output logic      [7:0]       regRdData,
  input  wire logic             controlInputOne,
  input  wire logic             controlInputTwo,
  input  wire logic             controlInputFour,
  input  wire logic             controlInputFive,
  input  wire logic             terminationLdoGood,
  input  wire logic             loadSwitchBOneGood,
  input  wire logic             loadSwitchBTwoStatus,
  input  wire logic             loadSwitchAOneGood,
  input  wire logic             linearRegATwoGood,
  input  wire logic             linearRegAThreeGood,
  input  wire logic [RAILS-1:0] stepDownGood,
  output logic                  powerGoodOutD,
  output logic                  powerGoodOutB
);

  pgt_state_t stateQ;
  pgt_state_t stateD;

  // Sources of each tree, packed in the same bit order as their masks.
  logic [8:0]       srcD;
  logic [8:0]       maskD;
  logic [8:0]       passD;
  logic [RAILS+1:0] srcB;
  logic [RAILS+1:0] maskB;
  logic [RAILS+1:0] passB;

  // Tree D: bit 8 is step-down rail 1, bits 7..0 follow the second mask.
  assign srcD = {stepDownGood[0], controlInputFive, controlInputFour,
                 controlInputTwo, controlInputOne, terminationLdoGood,
                 loadSwitchBTwoStatus, loadSwitchBOneGood,
                 linearRegAThreeGood};
  assign maskD = {stateQ.maskDOneBit0, stateQ.maskDTwo};
  assign srcB  = {linearRegATwoGood, loadSwitchAOneGood, stepDownGood};
  assign maskB = stateQ.maskBOne;
  // Only bit 0 of the first D mask is stored; its other bits read as zero.
  // Those bits steer rails that this block never sees, so they are dropped.

  // A set mask bit forces its source to pass, so it cannot pull the tree.
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++)
    begin : g_tree_d
      assign passD[gi] = srcD[gi] | maskD[gi];
    end
    for (gi = 0; gi < RAILS + 2; gi++)
    begin : g_tree_b
      assign passB[gi] = srcB[gi] | maskB[gi];
    end
  endgenerate

  // Next state: register writes, read capture and both trees.
  always_comb
  begin
    stateD = stateQ;
    if (regWrEn)
    begin
      unique case (regAddr)
        PGT_ADDR_D_MASK_TWO: stateD.maskDTwo = regWrData;
        PGT_ADDR_B_MASK_ONE: stateD.maskBOne = regWrData;
        PGT_ADDR_D_MASK_ONE:
          stateD.maskDOneBit0 = regWrData[PGT_BIT_D_STEP_DOWN_ONE_EXCL];
        default: ;
      endcase
    end
    // A read in the same cycle as a write returns the old contents.
    if (regRdEn)
    begin
      unique case (regAddr)
        PGT_ADDR_D_MASK_TWO: stateD.rdData = stateQ.maskDTwo;
        PGT_ADDR_B_MASK_ONE: stateD.rdData = stateQ.maskBOne;
        PGT_ADDR_D_MASK_ONE: stateD.rdData = {7'h00, stateQ.maskDOneBit0};
        default:             stateD.rdData = 8'h00;
      endcase
    end
    // Registering the trees costs one cycle but keeps outputs glitch free.
    stateD.pgD = &passD;
    stateD.pgB = &passB;
  end

  // State register with synchronous active-low reset.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      stateQ.maskDTwo     <= PGT_RST_D_MASK_TWO;
      stateQ.maskBOne     <= PGT_RST_B_MASK_ONE;
      stateQ.maskDOneBit0 <= PGT_RST_D_MASK_ONE[PGT_BIT_D_STEP_DOWN_ONE_EXCL];
      stateQ.rdData       <= 8'h00;
      stateQ.pgD          <= 1'b0;
      stateQ.pgB          <= 1'b0;
    end
    else
    begin
      stateQ <= stateD;
    end
  end

  assign regRdData     = stateQ.rdData;
  assign powerGoodOutD = stateQ.pgD;
  assign powerGoodOutB = stateQ.pgB;

  // Checks on register behaviour. The reset checks look at the first edge
  // after release only, since the state is unknown before any reset edge.
  AST_D_TWO_RESET: assert property (
    @(posedge clk) !$past(resetn) && resetn |->
    stateQ.maskDTwo == PGT_RST_D_MASK_TWO)
    else $error("Output D second mask did not reset to zero.");

  AST_D_TWO_RW: assert property (
    @(posedge clk) disable iff (!resetn)
    regWrEn && regAddr == PGT_ADDR_D_MASK_TWO
    |=> stateQ.maskDTwo == $past(regWrData))
    else $error("Output D second mask did not take the written byte.");

  AST_D_TWO_RD: assert property (
    @(posedge clk) disable iff (!resetn)
    regRdEn && regAddr == PGT_ADDR_D_MASK_TWO
    |=> regRdData == $past(stateQ.maskDTwo))
    else $error("Output D second mask read back differs from store.");

  AST_D_TWO_HOLD: assert property (
    @(posedge clk) disable iff (!resetn)
    !(regWrEn && regAddr == PGT_ADDR_D_MASK_TWO)
    |=> $stable(stateQ.maskDTwo))
    else $error("Output D second mask changed without a write.");

  AST_B_ONE_RESET: assert property (
    @(posedge clk) !$past(resetn) && resetn |->
    stateQ.maskBOne == PGT_RST_B_MASK_ONE)
    else $error("Output B first mask did not reset to C0h.");

  AST_B_ONE_RW: assert property (
    @(posedge clk) disable iff (!resetn)
    regWrEn && regAddr == PGT_ADDR_B_MASK_ONE
    |=> stateQ.maskBOne == $past(regWrData))
    else $error("Output B first mask did not take the written byte.");

  AST_B_ONE_RD: assert property (
    @(posedge clk) disable iff (!resetn)
    regRdEn && regAddr == PGT_ADDR_B_MASK_ONE
    |=> regRdData == $past(stateQ.maskBOne))
    else $error("Output B first mask read back differs from store.");

  AST_B_ONE_HOLD: assert property (
    @(posedge clk) disable iff (!resetn)
    !(regWrEn && regAddr == PGT_ADDR_B_MASK_ONE)
    |=> $stable(stateQ.maskBOne))
    else $error("Output B first mask changed without a write.");

  AST_D_ONE_RESET: assert property (
    @(posedge clk) !$past(resetn) && resetn |-> !stateQ.maskDOneBit0)
    else $error("Output D first mask bit did not reset to zero.");

  AST_D_ONE_WR: assert property (
    @(posedge clk) disable iff (!resetn)
    regWrEn && regAddr == PGT_ADDR_D_MASK_ONE
    |=> stateQ.maskDOneBit0 == $past(regWrData[0]))
    else $error("Output D first mask bit did not take the write.");

  AST_D_ONE_RD: assert property (
    @(posedge clk) disable iff (!resetn)
    regRdEn && regAddr == PGT_ADDR_D_MASK_ONE
    |=> regRdData == {7'h00, $past(stateQ.maskDOneBit0)})
    else $error("Output D first mask read back differs from store.");

  AST_D_ONE_HOLD: assert property (
    @(posedge clk) disable iff (!resetn)
    !(regWrEn && regAddr == PGT_ADDR_D_MASK_ONE)
    |=> $stable(stateQ.maskDOneBit0))
    else $error("Output D first mask bit changed without a write.");

  // Bytes that no register claims read as zero, and read data stands.
  AST_RD_UNMAPPED: assert property (
    @(posedge clk) disable iff (!resetn)
    regRdEn && regAddr != PGT_ADDR_D_MASK_ONE &&
    regAddr != PGT_ADDR_D_MASK_TWO && regAddr != PGT_ADDR_B_MASK_ONE
    |=> regRdData == 8'h00)
    else $error("Unmapped address did not read as zero.");

  AST_RD_HOLD: assert property (
    @(posedge clk) disable iff (!resetn)
    !regRdEn |=> $stable(regRdData))
    else $error("Read data changed without a read.");

  AST_OUT_RESET: assert property (
    @(posedge clk) !$past(resetn) && resetn |->
    !powerGoodOutD && !powerGoodOutB && regRdData == 8'h00)
    else $error("Outputs not cleared by reset.");

  // Checks that an unmasked failing source pulls its tree low.
  AST_D_CTL_FIVE: assert property (
    @(posedge clk) disable iff (!resetn)
    !stateQ.maskDTwo[7] && !controlInputFive |=> !powerGoodOutD)
    else $error("Control input five not honoured in tree D.");

  AST_D_CTL_FOUR: assert property (
    @(posedge clk) disable iff (!resetn)
    !stateQ.maskDTwo[6] && !controlInputFour |=> !powerGoodOutD)
    else $error("Control input four not honoured in tree D.");

  AST_D_CTL_TWO_ONE: assert property (
    @(posedge clk) disable iff (!resetn)
    (!stateQ.maskDTwo[5] && !controlInputTwo) ||
    (!stateQ.maskDTwo[4] && !controlInputOne) |=> !powerGoodOutD)
    else $error("Control inputs two or one not honoured in tree D.");

  AST_D_TERM: assert property (
    @(posedge clk) disable iff (!resetn)
    !stateQ.maskDTwo[3] && !terminationLdoGood |=> !powerGoodOutD)
    else $error("Termination regulator not honoured in tree D.");

  AST_D_SW_B_TWO: assert property (
    @(posedge clk) disable iff (!resetn)
    !stateQ.maskDTwo[2] && !loadSwitchBTwoStatus |=> !powerGoodOutD)
    else $error("Load switch B2 not honoured in tree D.");

  AST_D_SW_B_ONE: assert property (
    @(posedge clk) disable iff (!resetn)
    !stateQ.maskDTwo[1] && !loadSwitchBOneGood |=> !powerGoodOutD)
    else $error("Load switch B1 not honoured in tree D.");

  AST_D_LIN_A_THREE: assert property (
    @(posedge clk) disable iff (!resetn)
    !stateQ.maskDTwo[0] && !linearRegAThreeGood |=> !powerGoodOutD)
    else $error("Linear regulator A3 not honoured in tree D.");

  AST_D_STEP_ONE: assert property (
    @(posedge clk) disable iff (!resetn)
    !stateQ.maskDOneBit0 && !stepDownGood[0] |=> !powerGoodOutD)
    else $error("Step-down rail 1 not honoured in tree D.");

  AST_B_LIN_A_TWO: assert property (
    @(posedge clk) disable iff (!resetn)
    !stateQ.maskBOne[7] && !linearRegATwoGood |=> !powerGoodOutB)
    else $error("Linear regulator A2 not honoured in tree B.");

  AST_B_SW_A_ONE: assert property (
    @(posedge clk) disable iff (!resetn)
    !stateQ.maskBOne[6] && !loadSwitchAOneGood |=> !powerGoodOutB)
    else $error("Load switch A1 not honoured in tree B.");

  AST_B_STEP_RAILS: assert property (
    @(posedge clk) disable iff (!resetn)
    |(~stateQ.maskBOne[RAILS-1:0] & ~stepDownGood) |=> !powerGoodOutB)
    else $error("A step-down rail not honoured in tree B.");

  // Checks that masked sources never hold a tree low.
  AST_D_ALL_PASS: assert property (
    @(posedge clk) disable iff (!resetn)
    &(srcD | maskD) |=> powerGoodOutD)
    else $error("Tree D low although every unmasked source is good.");

  AST_B_ALL_PASS: assert property (
    @(posedge clk) disable iff (!resetn)
    &(srcB | maskB) |=> powerGoodOutB)
    else $error("Tree B low although every unmasked source is good.");

  AST_B_DEFAULT_IGNORE: assert property (
    @(posedge clk) $past(resetn) == 1'b0 ##0 resetn
    ##0 (&stepDownGood) |=> powerGoodOutB)
    else $error("Tree B not good from rails alone after reset.");

  // A tree is low whenever some unmasked source is low, and only then.
  AST_D_ANY_FAIL: assert property (
    @(posedge clk) disable iff (!resetn)
    !(&(srcD | maskD)) |=> !powerGoodOutD)
    else $error("Tree D good although an unmasked source failed.");

  AST_B_ANY_FAIL: assert property (
    @(posedge clk) disable iff (!resetn)
    !(&(srcB | maskB)) |=> !powerGoodOutB)
    else $error("Tree B good although an unmasked source failed.");

  // With sources and masks steady the registered outputs must not move.
  AST_D_STEADY: assert property (
    @(posedge clk) disable iff (!resetn)
    $past(resetn) && $stable(srcD) && $stable(maskD)
    |=> $stable(powerGoodOutD))
    else $error("Tree D output moved with steady inputs.");

  AST_B_STEADY: assert property (
    @(posedge clk) disable iff (!resetn)
    $past(resetn) && $stable(srcB) && $stable(maskB)
    |=> $stable(powerGoodOutB))
    else $error("Tree B output moved with steady inputs.");

endmodule // pgt_power_good_tree_masks

// [pgt_power_good_tree_masks_tb.sv]
module pgt_power_good_tree_masks_tb
  import pgt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  wire  [7:0] regAddr, regWrData, regRdData;
  wire        regWrEn, regRdEn, powerGoodOutD, powerGoodOutB;
  logic [7:0] srcD = 8'hFF, srcB = 8'hFF, mD2, mB1;
  logic       mD1, rdPend = 1'b0, pgChk = 1'b0;
  logic [1:0] pgNote;
  logic [7:0] rdQ[$];
  logic [1:0] pgQ[$];
  integer     seed = 32'h26F5, error_cnt = 0, n_tests = 0, r;

  // The 40 ns clock.
  always #20 clk = ~clk;

  pgt_host_model host (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn));

  pgt_power_good_tree_masks dut (.clk(clk), .resetn(resetn),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData),
    .controlInputOne(srcD[4]), .controlInputTwo(srcD[5]),
    .controlInputFour(srcD[6]), .controlInputFive(srcD[7]),
    .terminationLdoGood(srcD[3]), .loadSwitchBOneGood(srcD[1]),
    .loadSwitchBTwoStatus(srcD[2]), .loadSwitchAOneGood(srcB[6]),
    .linearRegATwoGood(srcB[7]), .linearRegAThreeGood(srcD[0]),
    .stepDownGood(srcB[5:0]), .powerGoodOutD(powerGoodOutD),
    .powerGoodOutB(powerGoodOutB));

  task automatic cmpRd(input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] regRdData expected %h seen %h", e, g);
    end
  endtask

  task automatic cmpPg(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Results are compared in the cycle they stand, oldest note first.
  always @(posedge clk)
  begin
    rdPend <= regRdEn;
    if (rdPend)
      cmpRd(rdQ.pop_front(), regRdData);
    if (pgChk)
    begin
      pgNote = pgQ.pop_front();
      cmpPg("powerGoodOutD", pgNote[1], powerGoodOutD);
      cmpPg("powerGoodOutB", pgNote[0], powerGoodOutB);
    end
  end

  // Writes also update the bench's own copy of the masks.
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    if (a == PGT_ADDR_D_MASK_TWO) mD2 = d;
    if (a == PGT_ADDR_B_MASK_ONE) mB1 = d;
    if (a == PGT_ADDR_D_MASK_ONE) mD1 = d[0];
  endtask

  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    rdQ.push_back(e);
    host.rd(a);
  endtask

  // Each output is the AND of every source or its mask; three edges to settle.
  task automatic pgCheck(input logic [15:0] s);
    @(posedge clk);
    srcD <= s[7:0];
    srcB <= s[15:8];
    repeat (3) @(posedge clk);
    pgQ.push_back({&(s[7:0] | mD2) & (s[8] | mD1), &(s[15:8] | mB1)});
    pgChk <= 1'b1;
    @(posedge clk);
    pgChk <= 1'b0;
  endtask

  // Reset values, plus an unmapped byte that must read as zero.
  task automatic resetCheck();
    resetn <= 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    mD2 = 8'h00; mB1 = 8'hC0; mD1 = 1'b0;
    rreg(PGT_ADDR_D_MASK_TWO, 8'h00);
    rreg(PGT_ADDR_B_MASK_ONE, 8'hC0);
    rreg(PGT_ADDR_D_MASK_ONE, 8'h00);
    rreg(8'hA5, 8'h00);
    pgCheck(16'h3FFF);
    pgCheck(16'hFFFE);
    $display("test reset done");
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the several hundred cycles the tests need.
  initial
  begin
    #(40 * 20000);
    error_cnt++;
    complete_run();
  end

  initial
  begin
    resetCheck();
    // Back-to-back writes and reads; only bit 0 of the first D mask is kept.
    wreg(PGT_ADDR_D_MASK_TWO, 8'h5A);
    wreg(PGT_ADDR_B_MASK_ONE, 8'h3C);
    wreg(PGT_ADDR_D_MASK_ONE, 8'hFF);
    rreg(PGT_ADDR_D_MASK_TWO, 8'h5A);
    rreg(PGT_ADDR_B_MASK_ONE, 8'h3C);
    rreg(PGT_ADDR_D_MASK_ONE, 8'h01);
    $display("test readback done");
    // One failing source at a time, first included, then excluded.
    for (int m = 0; m < 2; m++)
    begin
      wreg(PGT_ADDR_D_MASK_TWO, m ? 8'hFF : 8'h00);
      wreg(PGT_ADDR_B_MASK_ONE, m ? 8'hFF : 8'h00);
      wreg(PGT_ADDR_D_MASK_ONE, m ? 8'h01 : 8'h00);
      for (int i = 0; i < 16; i++)
        pgCheck(16'hFFFF ^ (16'h0001 << i));
    end
    $display("test walking source done");
    // Random masks against random double failures, or none when both picks coincide.
    for (int k = 0; k < 40; k++)
    begin
      r = $random(seed);
      wreg(PGT_ADDR_D_MASK_TWO, r[7:0]);
      wreg(PGT_ADDR_B_MASK_ONE, r[15:8]);
      wreg(PGT_ADDR_D_MASK_ONE, {7'h00, r[16]});
      r = $random(seed);
      pgCheck(16'hFFFF ^ (16'h0001 << r[3:0]) ^ (16'h0001 << r[7:4]));
    end
    $display("test random done");
    resetCheck();
    complete_run();
  end
endmodule // pgt_power_good_tree_masks_tb
